// File: scrc_ctrl.sv
/*
  scrc_ctrl: sdram configuration and refresh timing controller.
  holds the config and refresh timer registers on axi4-lite, runs
  the refresh down-counter and issues refresh and init requests.
  assumes: the command sequencer consumes the refresh request level and init pulses
  and reports when a refresh command has been sent.
*/
// Decided for this implementation: the AXI4-Lite slave port and the address map.
// Operation
// - timing fields are cycles minus one
// - activate_to_access_time kept despite early write data
// - writing init one starts initialization
// - refresh enable bit gates refresh
// - legacy page bit selects 9/8 columns
// - column field selects 9, 8, 10 pins
// - row field selects 11, 12, 13 pins
// - bank bit selects one or two pins
// - refresh counts interface clock cycles
// - counter decrements, reloads at zero
// - extra refresh field sets refresh count
// - refresh expiry preempts ongoing accesses
// - counter field reads live counter
// - period field resets to 0x5DC
`timescale 1ns/1ps
module scrc_ctrl #(
  parameter bit LEGACY = 1'b0 // 1: legacy variant, half cpu rate
) (
  input wire logic aclk, // 40 MHz clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [3:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [3:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic refresh_done, // sequencer sent one refresh
  output logic refresh_req, // refresh owed, preempt accesses
  output logic init_start, // one-cycle init trigger
  output logic init_busy, // init sequence window
  output scrc_pkg::scrc_timing_t timing, // timing for sequencer
  output scrc_pkg::scrc_geom_t geom // address geometry
);
  import scrc_pkg::*;

  // ****************************************
  // registers
  // ****************************************
  logic [31:0] cfg_ff; // config register, init bit reads zero
  logic [11:0] period_ff; // refresh reload value
  logic [1:0] extra_refresh_count_ff; // extra refresh count
  logic [11:0] cnt_ff; // refresh down-counter
  logic [2:0] owed_ff; // refreshes still owed
  logic tick_ff; // interface cycle enable
  logic [7:0] init_cnt_ff; // init busy counter
  logic aw_ff, w_ff; // captured write halves
  logic [3:0] awaddr_ff; // captured write address
  logic [31:0] wdata_ff; // captured write data
  logic [3:0] wstrb_ff; // captured strobes

  // ****************************************
  // write channel decode
  // ****************************************
  wire aw_take = s_axi_awvalid & s_axi_awready; // address accepted
  wire w_take = s_axi_wvalid & s_axi_wready; // data accepted
  wire wr_go = aw_ff & w_ff & ~s_axi_bvalid; // both halves present
  wire [31:0] bmask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}},
                       {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
  wire wr_cfg = wr_go & (awaddr_ff == ADDR_CONFIG); // config hit
  wire wr_tim = wr_go & (awaddr_ff == ADDR_TIMER); // timer hit
  wire wr_ok = wr_cfg | wr_tim | (wr_go & awaddr_ff == ADDR_STATUS);
  wire [31:0] cfg_merge = (cfg_ff & ~bmask) | (wdata_ff & bmask);
  wire [31:0] tim_cur = {6'h00, extra_refresh_count_ff, cnt_ff, period_ff};
  wire [31:0] tim_merge = (tim_cur & ~bmask) | (wdata_ff & bmask);
  // init trigger: only a written one with its lane enabled
  wire init_hit = wr_cfg & wstrb_ff[3] & wdata_ff[CFG_INIT];

  // ****************************************
  // refresh timing decode
  // ****************************************
  // legacy interface cycle is two clocks; extended is every clock
  wire tick = LEGACY ? tick_ff : 1'b1;
  wire refresh_enable = cfg_ff[CFG_REFRESH_ENABLE];
  wire expire = refresh_enable & tick & (cnt_ff == 12'h000);
  // legacy has one refresh per expiry; extended n gives n+1
  wire [2:0] per_exp = LEGACY ? 3'h1 :
                       ({1'b0, extra_refresh_count_ff} + 3'h1);
  wire [2:0] owed_sum = owed_ff + per_exp; // owed plus new batch
  wire owed_dec = refresh_done & (owed_ff != 3'h0); // one sent

  // ****************************************
  // geometry decode
  // ****************************************
  wire [1:0] col_code = cfg_ff[CFG_COL_HI:CFG_COL_LO];
  wire [1:0] row_code = cfg_ff[CFG_ROW_HI:CFG_ROW_LO];
  wire [3:0] col_ext = (col_code == 2'h1) ? 4'h8 :
                       (col_code == 2'h2) ? 4'hA : 4'h9;
  wire [3:0] col_leg = cfg_ff[CFG_PAGE] ? 4'h8 : 4'h9;
  wire [3:0] row_bits = (row_code == 2'h1) ? 4'hC :
                        (row_code == 2'h2) ? 4'hD : 4'hB;
  wire [2:0] bank_pins = cfg_ff[CFG_BANK] ? 3'h2 : 3'h1;

  // ****************************************
  // read decode
  // ****************************************
  wire ar_take = s_axi_arvalid & s_axi_arready; // read accepted
  wire rd_cfg = s_axi_araddr == ADDR_CONFIG; // config hit
  wire rd_tim = s_axi_araddr == ADDR_TIMER; // timer hit
  wire rd_sts = s_axi_araddr == ADDR_STATUS; // status hit
  // counter field shows the live down-counter
  wire [31:0] rd_val = rd_cfg ? cfg_ff :
                       rd_tim ? tim_cur :
                       rd_sts ? {27'h0, init_busy, refresh_req,
                                 owed_ff} : 32'h0000_0000;

  // ****************************************
  // write address and data capture
  // ****************************************
  // each half taken independently, held until response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awaddr_ff <= 4'h0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_ff <= 1'b0;
      end
      if (w_take) begin
        w_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end else if (wr_go) begin
        w_ff <= 1'b0;
      end
    end
  end

  // ready while the half is empty and no response pends
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= ~aw_ff & ~aw_take & ~s_axi_bvalid & ~wr_go;
      s_axi_wready <= ~w_ff & ~w_take & ~s_axi_bvalid & ~wr_go;
    end
  end

  // write response, slverr on unmapped address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************
  // read channel
  // ****************************************
  // one read at a time, data registered one cycle after address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~ar_take;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= (rd_cfg | rd_tim | rd_sts) ? RESP_OKAY
                                                  : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // configuration registers
  // ****************************************
  // init bit never stored, so it reads back zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_ff <= CFG_RESET;
      period_ff <= PERIOD_RESET;
      extra_refresh_count_ff <= EXTRA_REFRESH_COUNT_RESET;
    end else begin
      if (wr_cfg) begin
        cfg_ff <= cfg_merge & CFG_WMASK;
      end
      if (wr_tim) begin
        period_ff <= tim_merge[11:0];
        extra_refresh_count_ff <= LEGACY ? 2'h0 : tim_merge[TIM_EXTRA_REFRESH_COUNT_HI:TIM_EXTRA_REFRESH_COUNT_LO];
      end
    end
  end

  // ****************************************
  // refresh timing
  // ****************************************
  // interface-cycle divider for the legacy variant
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= ~tick_ff;
    end
  end

  // down-counter, reloads from period on reaching zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff <= PERIOD_RESET;
    end else if (tick) begin
      if (cnt_ff == 12'h000) begin
        cnt_ff <= period_ff;
      end else begin
        cnt_ff <= cnt_ff - 12'h001;
      end
    end
  end

  // owed refreshes; new expiry adds while one retires
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      owed_ff <= 3'h0;
      refresh_req <= 1'b0;
    end else if (!refresh_enable) begin
      owed_ff <= 3'h0;
      refresh_req <= 1'b0;
    end else begin
      if (expire) begin
        owed_ff <= owed_dec ? owed_sum - 3'h1 : owed_sum;
      end else if (owed_dec) begin
        owed_ff <= owed_ff - 3'h1;
      end
      // urgent at every expiry: sequencer preempts accesses
      refresh_req <= expire | (owed_ff > {2'h0, owed_dec});
    end
  end

  // ****************************************
  // initialization trigger
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      init_start <= 1'b0;
      init_busy <= 1'b0;
      init_cnt_ff <= 8'h00;
    end else begin
      init_start <= init_hit;
      if (init_hit) begin
        init_busy <= 1'b1;
        init_cnt_ff <= 8'(INIT_CYCLES);
      end else if (init_busy & tick) begin
        init_cnt_ff <= init_cnt_ff - 8'h01;
        init_busy <= (init_cnt_ff != 8'h01);
      end
    end
  end

  // ****************************************
  // timing and geometry outputs
  // ****************************************
  // fields passed as cycles minus one; activate_to_access_time counted from activate
  // to the command itself, independent of early write data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // reset shows the reset fields, never an all-zero geometry
      timing <= '{row_cycle_time: CFG_RESET[CFG_TRC_HI:CFG_TRC_LO],
                  precharge_time: CFG_RESET[CFG_TRP_HI:CFG_TRP_LO],
                  activate_to_access_time: CFG_RESET[CFG_ACTIVATE_TO_ACCESS_TIME_HI:CFG_ACTIVATE_TO_ACCESS_TIME_LO]};
      geom <= '{col_bits: 4'h9, row_bits: 4'hB, bank_pins: 3'h1};
    end else begin
      timing.row_cycle_time <= cfg_ff[CFG_TRC_HI:CFG_TRC_LO];
      timing.precharge_time <= cfg_ff[CFG_TRP_HI:CFG_TRP_LO];
      timing.activate_to_access_time <= cfg_ff[CFG_ACTIVATE_TO_ACCESS_TIME_HI:CFG_ACTIVATE_TO_ACCESS_TIME_LO];
      geom.col_bits <= LEGACY ? col_leg : col_ext;
      geom.row_bits <= row_bits;
      geom.bank_pins <= bank_pins;
    end
  end
endmodule

// File: scrc_pkg.sv
/*
  scrc_pkg: shared constants and carrier types for the sdram
  configuration and refresh timing block.
  assumes: 32-bit axi4-lite register bus, single 40 MHz clock.
*/
package scrc_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [3:0] ADDR_CONFIG = 4'h0; // sdram_config_register
  localparam logic [3:0] ADDR_TIMER = 4'h4; // refresh_timer_register
  localparam logic [3:0] ADDR_STATUS = 4'h8; // status / refresh count
  // ****************************************
  // config register fields
  // ****************************************
  localparam int CFG_BANK = 30; // bank_size
  localparam int CFG_ROW_HI = 29; // row_size
  localparam int CFG_ROW_LO = 28;
  localparam int CFG_COL_HI = 27; // column_size
  localparam int CFG_COL_LO = 26;
  localparam int CFG_PAGE = 26; // page_width_select (legacy)
  localparam int CFG_REFRESH_ENABLE = 25; // refresh_enable
  localparam int CFG_INIT = 24; // init trigger, self clearing
  localparam int CFG_ACTIVATE_TO_ACCESS_TIME_HI = 23; // activate_to_access_time
  localparam int CFG_ACTIVATE_TO_ACCESS_TIME_LO = 20;
  localparam int CFG_TRP_HI = 19; // precharge_time
  localparam int CFG_TRP_LO = 16;
  localparam int CFG_TRC_HI = 15; // row_cycle_time
  localparam int CFG_TRC_LO = 12;
  localparam logic [31:0] CFG_RESET = 32'h0248_F000;
  localparam logic [31:0] CFG_WMASK = 32'h7EFF_F000;
  // ****************************************
  // timer register fields
  // ****************************************
  localparam int TIM_EXTRA_REFRESH_COUNT_HI = 25;
  localparam int TIM_EXTRA_REFRESH_COUNT_LO = 24;
  localparam int TIM_CNT_HI = 23;
  localparam int TIM_CNT_LO = 12;
  localparam logic [11:0] PERIOD_RESET = 12'h5DC;
  localparam logic [1:0] EXTRA_REFRESH_COUNT_RESET = 2'h0;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ = 40;
  localparam int INIT_CYCLES = 8; // interface cycles of init busy
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic [3:0] row_cycle_time; // row cycle minus one
    logic [3:0] precharge_time; // precharge minus one
    logic [3:0] activate_to_access_time; // activate to access minus one
  } scrc_timing_t;
  typedef struct packed {
    logic [3:0] col_bits; // column address pins
    logic [3:0] row_bits; // row address pins
    logic [2:0] bank_pins; // bank-select pins
  } scrc_geom_t;
endpackage

// File: scrc_monitor.sv
/*
  scrc_monitor: port assertions for scrc_ctrl.
  assumes: bound onto scrc_ctrl, one clock, sync reset.
*/
`timescale 1ns/1ps
module scrc_monitor
  import scrc_pkg::*;
(
  input wire logic aclk, // clock
  input wire logic aresetn, // reset, active low
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic s_axi_bvalid, // b valid
  input wire logic s_axi_bready, // b ready
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic s_axi_rvalid, // r valid
  input wire logic s_axi_rready, // r ready
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic init_start, // init pulse
  input wire logic init_busy, // init window
  input wire scrc_pkg::scrc_timing_t timing, // timing fields
  input wire scrc_pkg::scrc_geom_t geom // decoded geometry
);
  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // both write halves taken at one edge
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // one-cycle init trigger
  sequence s_init;
    init_start ##1 !init_start;
  endsequence
  property p_wr_resp;
    s_wr_take |-> ##2 s_axi_bvalid;
  endproperty
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  property p_rd_resp;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_init_pulse;
    init_start |-> s_init ##[0:1] init_busy;
  endproperty
  property p_init_busy;
    $rose(init_busy) |-> init_busy[*8] ##1 !init_busy;
  endproperty
  property p_reset_vals;
    $rose(aresetn) |-> timing == 12'hF84 && geom == 11'h4D9;
  endproperty
  property p_geom;
    geom.col_bits inside {4'h8, 4'h9, 4'hA} &&
      geom.row_bits inside {4'hB, 4'hC, 4'hD} &&
      geom.bank_pins inside {3'h1, 3'h2};
  endproperty
  a_wr_resp: assert property (p_wr_resp)
    else $error("write response late");
  a_b_hold: assert property (p_b_hold)
    else $error("bvalid dropped early");
  a_rd_resp: assert property (p_rd_resp)
    else $error("read data late");
  a_r_hold: assert property (p_r_hold)
    else $error("read data not held");
  a_init_pulse: assert property (p_init_pulse)
    else $error("init trigger malformed");
  a_init_busy: assert property (p_init_busy)
    else $error("init window length wrong");
  a_reset_vals: assert property (p_reset_vals)
    else $error("reset timing or geometry wrong");
  a_geom: assert property (p_geom)
    else $error("geometry out of range");
endmodule
bind scrc_ctrl scrc_monitor u_mon (.*);

// File: scrc_seq_model.sv
/*
  scrc_seq_model: command sequencer stand-in serving owed refreshes.
  assumes: refresh_req is a level, refresh_done a one-cycle pulse.
*/
`timescale 1ns/1ps
module scrc_seq_model (
  input wire logic aclk, // clock
  input wire logic aresetn, // reset, active low
  input wire logic refresh_req, // refreshes owed
  input wire logic slow, // 1: answer late
  output logic refresh_done // one refresh sent
);
  logic [3:0] wait_ff; // cycles to next action
  // one refresh per visit, then rest so the owed count can settle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wait_ff <= 4'h0;
      refresh_done <= 1'b0;
    end else begin
      refresh_done <= (wait_ff == 4'h3);
      if (wait_ff != 4'h0) begin
        wait_ff <= wait_ff - 4'h1;
      end else if (refresh_req) begin
        wait_ff <= slow ? 4'h8 : 4'h4;
      end
    end
  end
endmodule

// File: scrc_tb.sv
/*
  testbench: register and refresh scenarios for scrc_ctrl.
  assumes: scrc_seq_model answers refresh requests.
*/
`timescale 1ns/1ps
module testbench;
  import scrc_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0;
  logic s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF; // whole words except the low-lane timer write in t_off
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic [3:0] s_axi_araddr = 4'h0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic slow = 1'b0; // partner answers late
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, refresh_done, refresh_req, init_start, init_busy;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  scrc_timing_t timing;
  scrc_geom_t geom;
  int failures = 0;
  int comparisons = 0;
  int inits = 0;
  int dones = 0;
  always #12.5 aclk = ~aclk;
  // count trigger and refresh pulses mid-cycle
  always @(negedge aclk) begin
    if (init_start === 1'b1) inits++;
    if (refresh_done === 1'b1) dones++;
  end
  scrc_ctrl uut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .refresh_done(refresh_done),
    .refresh_req(refresh_req), .init_start(init_start),
    .init_busy(init_busy), .timing(timing), .geom(geom));
  scrc_seq_model u_seq (.aclk(aclk), .aresetn(aresetn),
    .refresh_req(refresh_req), .slow(slow), .refresh_done(refresh_done));
  task automatic report_and_stop();
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      failures++;
    end
  endtask
  // bound every wait
  task automatic tick(inout int n);
    n++;
    if (n > 3000) begin
      failures++;
      report_and_stop();
    end
  endtask
  // readiness seen mid-cycle means taken at the next rising edge
  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    int n;
    logic ta, tw;
    n = 0;
    ta = 1'b0;
    tw = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(ta && tw)) begin
      @(negedge aclk);
      ta = ta | (s_axi_awready === 1'b1);
      tw = tw | (s_axi_wready === 1'b1);
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      tick(n);
    end
    do begin @(negedge aclk); tick(n); end while (s_axi_bvalid !== 1'b1);
    @(posedge aclk);
    s_axi_bready <= 1'b1;
    @(negedge aclk);
    r = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin @(negedge aclk); tick(n); end while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do begin @(negedge aclk); tick(n); end while (s_axi_rvalid !== 1'b1);
    @(posedge aclk);
    s_axi_rready <= 1'b1;
    @(negedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask
  task automatic wait_req(input logic lvl);
    int n;
    n = 0;
    do begin @(negedge aclk); tick(n); end while (refresh_req !== lvl);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    chk({20'h0, timing}, 32'h0000_0F84);
    chk({21'h0, geom}, 32'h0000_04D9);
    rd(ADDR_CONFIG, d, r);
    chk(d, 32'h0248_F000);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
    rd(ADDR_TIMER, d, r);
    chk(d & 32'hFF00_0FFF, 32'h0000_05DC);
  endtask
  // geometry codes 0 to 2 with refresh off
  task automatic t_geom();
    logic [31:0] d, c;
    logic [1:0] r;
    logic [10:0] g;
    logic [3:0] ce[3] = '{4'h9, 4'h8, 4'hA};
    logic [3:0] re[3] = '{4'hB, 4'hC, 4'hD};
    for (int i = 0; i < 3; i++) begin
      c = {1'b0, i[0], i[1:0], i[1:0], 2'h0, 4'h3, 4'h2, 4'h7, 12'h0};
      g = {ce[i], re[i], i[0] ? 3'h2 : 3'h1};
      wr(ADDR_CONFIG, c, r);
      chk({30'h0, r}, {30'h0, RESP_OKAY});
      rd(ADDR_CONFIG, d, r);
      chk(d, c);
      chk({20'h0, timing}, 32'h0000_0723);
      chk({21'h0, geom}, {21'h0, g});
    end
  endtask
  task automatic t_init();
    logic [31:0] d;
    logic [1:0] r;
    int k;
    k = inits;
    wr(ADDR_CONFIG, 32'h0048_F000, r);
    repeat (4) @(posedge aclk);
    chk(inits, k);
    wr(ADDR_CONFIG, 32'h0148_F000, r);
    @(negedge aclk);
    chk({31'h0, init_busy}, 32'h1);
    repeat (12) @(posedge aclk);
    chk(inits, k + 1);
    chk({31'h0, init_busy}, 32'h0);
    rd(ADDR_CONFIG, d, r);
    chk(d, 32'h0048_F000);
  endtask
  // refreshes per expiry for each extra count
  task automatic t_refresh();
    logic [1:0] r;
    int d0;
    wr(ADDR_CONFIG, 32'h0248_F000, r);
    for (int n = 0; n < 4; n++) begin
      slow <= (n == 0);
      wr(ADDR_TIMER, {6'h0, n[1:0], 12'h0, 12'h03C}, r);
      wait_req(1'b1);
      wait_req(1'b0);
      wait_req(1'b1);
      d0 = dones;
      repeat (213) @(negedge aclk);
      @(posedge aclk);
      chk(dones - d0, 4 * (n + 1));
    end
  endtask
  task automatic t_off();
    logic [31:0] d, e;
    logic [1:0] r;
    int d0;
    wr(ADDR_CONFIG, 32'h0048_F000, r);
    repeat (12) @(posedge aclk);
    d0 = dones;
    repeat (200) @(posedge aclk);
    chk(dones - d0, 0);
    rd(ADDR_TIMER, d, r);
    rd(ADDR_TIMER, e, r);
    chk(d[23:12] <= 12'h03C && d[23:12] != e[23:12], 1);
    rd(ADDR_STATUS, d, r);
    chk(d, 32'h0);
    // only the low lane lands: period low byte set, extra_refresh_count kept
    s_axi_wstrb <= 4'h1;
    wr(ADDR_TIMER, 32'hFFFF_FFFF, r);
    s_axi_wstrb <= 4'hF;
    rd(ADDR_TIMER, d, r);
    chk({18'h0, d[25:24], d[11:0]}, 32'h0000_30FF);
    wr(4'hC, 32'hFFFF_FFFF, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    rd(4'hC, d, r);
    chk(d, 32'h0);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
  endtask
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset();
    t_geom();
    t_init();
    t_refresh();
    t_off();
    report_and_stop();
  end
endmodule
